/* File: verilog/spfi_port.sv */
// spi port control, status, fault and irq logic
// assumes sfr bus on the peripheral clock; pins are asynchronous
`timescale 1ns/10ps
`include "spfi_defs.svh"
module spfi_port
  import spfi_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // sfr access
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // serial pins
  input wire spfi_pins_s pinIn,
  output logic sckOut,
  output logic sckOe,
  output logic mosiOut,
  output logic mosiOe,
  output logic misoOut,
  output logic misoOe,
  output logic selGpio,
  // interrupt requests
  output logic xferIrq,
  output logic modfIrq,
  output logic txeIrq
);
  spfi_state_s s_r, s_nxt;
  logic txValid;
  logic txReady;
  logic [7:0] txData;
  logic pushTx;

  // decoded rate divisor; zero means no generator
  function automatic logic [6:0] halfDiv(input logic [2:0] code);
    case (code)
      3'h1: halfDiv = 7'h01;
      3'h2: halfDiv = 7'h03;
      3'h3: halfDiv = 7'h07;
      3'h4: halfDiv = 7'h0f;
      3'h5: halfDiv = 7'h1f;
      3'h6: halfDiv = 7'h3f;
      default: halfDiv = 7'h00;
    endcase
  endfunction

  function automatic logic isAddr(input logic [7:0] a, input logic [7:0] b);
    isAddr = a == b;
  endfunction

  assign pushTx = sfrWr && isAddr(sfrAddr, `SPFI_ADDR_DATA) &&
    s_r.ctrl[`SPFI_BIT_EN];

  spfi_fifo #(.WIDTH(8), .DEPTH(`SPFI_FIFO_DEPTH)) txFifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .inValid(pushTx),
    .inReady(txReady),
    .inData(sfrWdata),
    .outValid(txValid),
    .outReady(s_r.popTx),
    .outData(txData)
  );

  always_comb begin
    logic en, master_select_bit, select_disable_bit, cpol, cpha, selDis, selected, selN;
    logic sck, sckEdge, lead, trail, sample, done, selRise, selFall;
    logic [7:0] rxByte;
    logic tick;
    en = 1'b0; master_select_bit = 1'b0; select_disable_bit = 1'b0; cpol = 1'b0; cpha = 1'b0;
    selDis = 1'b0; selected = 1'b0; selN = 1'b0; sck = 1'b0;
    sckEdge = 1'b0; lead = 1'b0; trail = 1'b0; sample = 1'b0;
    done = 1'b0; selRise = 1'b0; selFall = 1'b0; rxByte = 8'h00;
    tick = 1'b0;
    s_nxt = s_r;
    s_nxt.popTx = 1'b0;
    // two-stage pin synchronisers; only the second stage is read below
    s_nxt.sckSync = {s_r.sckSync[0], pinIn.sck};
    s_nxt.mosiSync = {s_r.mosiSync[0], pinIn.mosi};
    s_nxt.misoSync = {s_r.misoSync[0], pinIn.miso};
    s_nxt.selSync = {s_r.selSync[0], pinIn.selN};
    en = s_r.ctrl[`SPFI_BIT_EN];
    master_select_bit = s_r.ctrl[`SPFI_BIT_MASTER_SELECT_BIT];
    select_disable_bit = s_r.ctrl[`SPFI_BIT_SELECT_DISABLE_BIT];
    cpol = s_r.ctrl[`SPFI_BIT_CPOL];
    cpha = s_r.ctrl[`SPFI_BIT_CPHA];
    selDis = select_disable_bit && (master_select_bit || cpha);
    selN = s_r.selSync[1];
    selected = selDis ? 1'b1 : !selN;
    selRise = selN && !s_r.selPrev;
    selFall = !selN && s_r.selPrev;
    s_nxt.selPrev = selN;
    s_nxt.selGpio = selDis;
    // serial clock: generated in master, synchronised pin in slave
    sck = master_select_bit ? s_r.sckOut : s_r.sckSync[1];
    sckEdge = sck != s_r.sckPrev;
    s_nxt.sckPrev = sck;
    lead = sckEdge && (s_r.sckPrev == cpol);
    trail = sckEdge && (sck == cpol);
    sample = cpha ? trail : lead;

    // sfr reads
    s_nxt.rdData = 8'h00;
    if (sfrRd && isAddr(sfrAddr, `SPFI_ADDR_CTRL)) begin
      s_nxt.rdData = s_r.ctrl;
    end else if (sfrRd && isAddr(sfrAddr, `SPFI_ADDR_STAT)) begin
      s_nxt.rdData = {s_r.xfer, 1'b0, s_r.overrun_flag, s_r.mode_fault_flag, txReady,
        s_r.lsb, s_r.txeIe, s_r.mode_fault_irq_enable};
      s_nxt.statSeenX = s_r.xfer;
      s_nxt.statSeenM = s_r.mode_fault_flag;
      // overrun clears on status read
      s_nxt.overrun_flag = 1'b0;
    end else if (sfrRd && isAddr(sfrAddr, `SPFI_ADDR_DATA)) begin
      s_nxt.rdData = s_r.rxData;
    end
    if ((sfrRd || sfrWr) && isAddr(sfrAddr, `SPFI_ADDR_DATA) &&
        s_r.statSeenX) begin
      s_nxt.xfer = 1'b0;
      s_nxt.statSeenX = 1'b0;
    end
    if (sfrWr && isAddr(sfrAddr, `SPFI_ADDR_CTRL)) begin
      s_nxt.ctrl = sfrWdata;
      // fault cleared by read then write
      if (s_r.statSeenM) begin
        s_nxt.mode_fault_flag = 1'b0;
        s_nxt.statSeenM = 1'b0;
      end else if (s_r.mode_fault_flag) begin
        // enable may not return while fault stands
        s_nxt.ctrl[`SPFI_BIT_EN] = 1'b0;
      end
    end else if (sfrWr && isAddr(sfrAddr, `SPFI_ADDR_STAT)) begin
      s_nxt.lsb = sfrWdata[`SPFI_BIT_LSB];
      s_nxt.txeIe = sfrWdata[`SPFI_BIT_TXEIE];
      s_nxt.mode_fault_irq_enable = sfrWdata[`SPFI_BIT_MODE_FAULT_IRQ_ENABLE];
    end

    if (!en) begin
      s_nxt.state = ST_IDLE;
      s_nxt.bitCnt = 4'h0;
      s_nxt.div = 7'h00;
      s_nxt.sckOut = cpol;
      s_nxt.misoOe = 1'b0;
    end else if (master_select_bit) begin
      s_nxt.misoOe = 1'b0;
      // fault from select low in master
      if (!selDis && !selN) begin
        s_nxt.mode_fault_flag = 1'b1;
        s_nxt.ctrl[`SPFI_BIT_EN] = 1'b0;
        s_nxt.ctrl[`SPFI_BIT_MASTER_SELECT_BIT] = 1'b0;
        s_nxt.state = ST_IDLE;
        s_nxt.sckOut = cpol;
      end else begin
        tick = s_r.div == 7'h00;
        s_nxt.div = tick ? halfDiv({s_r.ctrl[`SPFI_BIT_RATE2],
          s_r.ctrl[1:0]}) : s_r.div - 7'h01;
        case (s_r.state)
          ST_IDLE: begin
            if (txValid && halfDiv({s_r.ctrl[`SPFI_BIT_RATE2],
                s_r.ctrl[1:0]}) != 7'h00) begin
              s_nxt.shift = txData;
              s_nxt.popTx = 1'b1;
              s_nxt.bitCnt = 4'h0;
              s_nxt.state = ST_SHIFT;
              s_nxt.mosiOut = s_r.lsb ? txData[0] : txData[7];
            end
          end
          ST_SHIFT: begin
            if (tick) begin
              s_nxt.sckOut = !s_r.sckOut;
            end
          end
          ST_TAIL: begin
            // tail handled below; must not fall back to idle early
            s_nxt.state = ST_TAIL;
          end
          default: begin
            s_nxt.state = ST_IDLE;
          end
        endcase
      end
    end else begin
      // unselected slave: tristate, clear, ignore clocks
      if (!selected) begin
        s_nxt.misoOe = 1'b0;
        s_nxt.bitCnt = 4'h0;
        s_nxt.state = ST_IDLE;
        if (selRise && s_r.state != ST_IDLE) begin
          s_nxt.mode_fault_flag = 1'b1;
        end
      end else begin
        s_nxt.misoOe = 1'b1;
        if (s_r.state == ST_IDLE && (selFall || (selDis && sckEdge))) begin
          s_nxt.state = ST_SHIFT;
          s_nxt.bitCnt = 4'h0;
          if (txValid) begin
            s_nxt.shift = txData;
            s_nxt.popTx = 1'b1;
          end
        end
      end
    end

    // shared shift engine on sample/shift edges
    if (en && s_r.state == ST_SHIFT && (master_select_bit || selected)) begin
      if (sample) begin
        if (s_r.lsb) begin
          s_nxt.shift = {(master_select_bit ? s_r.misoSync[1] : s_r.mosiSync[1]),
            s_r.shift[7:1]};
        end else begin
          s_nxt.shift = {s_r.shift[6:0],
            (master_select_bit ? s_r.misoSync[1] : s_r.mosiSync[1])};
        end
        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
        if (s_r.bitCnt == 4'h7) begin
          s_nxt.state = ST_TAIL;
        end
      end else if (sckEdge) begin
        s_nxt.mosiOut = s_r.lsb ? s_r.shift[0] : s_r.shift[7];
        s_nxt.misoOut = s_r.lsb ? s_r.shift[0] : s_r.shift[7];
      end
    end
    // end when clock back at idle
    if (en && s_r.state == ST_TAIL && (master_select_bit || selected)) begin
      if (master_select_bit && s_r.div == 7'h00 && s_r.sckOut != cpol) begin
        s_nxt.sckOut = cpol;
      end
      if (sck == cpol && !sckEdge) begin
        done = 1'b1;
        rxByte = s_r.shift;
        s_nxt.state = ST_IDLE;
      end
    end
    if (done) begin
      if (s_r.xfer) begin
        s_nxt.overrun_flag = 1'b1;
      end else begin
        s_nxt.rxData = rxByte;
      end
      s_nxt.xfer = 1'b1;
    end

    s_nxt.xferIrq = s_nxt.xfer && !s_nxt.txeIe;
    s_nxt.txeIrq = txReady && s_nxt.txeIe;
    s_nxt.modfIrq = s_nxt.mode_fault_flag && s_nxt.mode_fault_irq_enable && !select_disable_bit;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '0;
      s_r.ctrl <= `SPFI_CTRL_RESET;
      s_r.sckOut <= 1'b0;
      s_r.selSync <= 2'b11;
      s_r.selPrev <= 1'b1;
      s_r.state <= ST_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign sfrRdata = s_r.rdData;
  assign sckOut = s_r.sckOut;
  assign sckOe = s_r.ctrl[`SPFI_BIT_MASTER_SELECT_BIT] & s_r.ctrl[`SPFI_BIT_EN];
  assign mosiOut = s_r.mosiOut;
  assign mosiOe = sckOe;
  assign misoOut = s_r.misoOut;
  assign misoOe = s_r.misoOe;
  assign selGpio = s_r.selGpio;
  assign xferIrq = s_r.xferIrq;
  assign modfIrq = s_r.modfIrq;
  assign txeIrq = s_r.txeIrq;
endmodule

/* File: inc/spfi_defs.svh */
// constants for the serial port fault/irq control block
// assumes an 8-bit special function register port on the peripheral clock
// Functional notes
// - master with select enabled: select low sets mode fault, requests irq
// - master mode fault clears port enable and master select bits
// - mode fault clears on status read seeing it, then control write
// - master with select disabled: no fault, select pin free for gpio
// - slave: select rising during transmission flags mode fault
// - slave transfer starts on select fall, ends when clock idles after bit 8
// - select high: output tristated, bit counter cleared, clocks ignored
// - slave with select disabled: permanently selected, no fault
// - byte done while previous unread: overrun set, new byte dropped
// - transfer complete flag requests irq only while empty irq enable clear
// - transmit empty flag set while buffer can accept a byte
// - transmit empty irq only when its enable set
// - select disable set: no mode fault irq in any mode
// - slave with phase 0 ignores select disable bit; code still masks mode fault irq with it
// - clearing enable bit disables and resets port logic
// - master select bit: 0 slave, 1 master
// - polarity bit gives serial clock idle level
// - phase 0 samples on edge leaving idle
// - rate bits pick divide 4..128; codes 000 and 111 invalid
// - control register resets to 0x14
// - status layout: flag7 res6 ovr5 modf4 empty3 lsb2 ie1 ie0
// - transfer flag clears on data access after status read
// - mode fault irq enable gates mode fault request
// - lsb first mode bit chooses shift order
`ifndef SPFI_DEFS_SVH
`define SPFI_DEFS_SVH
`define SPFI_ADDR_CTRL 8'hd4
`define SPFI_ADDR_STAT 8'hd5
`define SPFI_ADDR_DATA 8'hd6
`define SPFI_CTRL_RESET 8'h14
`define SPFI_BIT_RATE2 7
`define SPFI_BIT_EN 6
`define SPFI_BIT_SELECT_DISABLE_BIT 5
`define SPFI_BIT_MASTER_SELECT_BIT 4
`define SPFI_BIT_CPOL 3
`define SPFI_BIT_CPHA 2
`define SPFI_BIT_XFER 7
`define SPFI_BIT_OVR 5
`define SPFI_BIT_MODE_FAULT_FLAG 4
`define SPFI_BIT_TXE 3
`define SPFI_BIT_LSB 2
`define SPFI_BIT_TXEIE 1
`define SPFI_BIT_MODE_FAULT_IRQ_ENABLE 0
`define SPFI_FIFO_DEPTH 32
`endif

/* File: inc/spfi_pkg.sv */
// types for the serial port fault/irq control block
// assumes spfi_defs.svh is included alongside
package spfi_pkg;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic selN;
  } spfi_pins_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_TAIL = 2'b10
  } spfi_state_e;
  typedef struct packed {
    logic [7:0] ctrl;
    logic xfer;
    logic overrun_flag;
    logic mode_fault_flag;
    logic lsb;
    logic txeIe;
    logic mode_fault_irq_enable;
    logic statSeenX;
    logic statSeenM;
    logic [7:0] rxData;
    logic [7:0] shift;
    logic [3:0] bitCnt;
    logic [6:0] div;
    spfi_state_e state;
    logic sckOut;
    logic mosiOut;
    logic misoOut;
    logic misoOe;
    logic [1:0] sckSync;
    logic [1:0] mosiSync;
    logic [1:0] misoSync;
    logic [1:0] selSync;
    logic sckPrev;
    logic selPrev;
    logic [7:0] rdData;
    logic xferIrq;
    logic modfIrq;
    logic txeIrq;
    logic popTx;
    logic selGpio;
  } spfi_state_s;
endpackage

/* File: verilog/spfi_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/10ps
module spfi_fifo
  import spfi_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clocking
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doWr;
  logic doRd;
  assign inReady = count_r != (AW+1)'(DEPTH);
  assign outValid = count_r != '0;
  assign outData = mem[rdPtr_r];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (doWr) begin
        mem[wrPtr_r] <= inData;
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule

/* File: bench/spfi_port_chk.sv */
// assertion checker for the serial port control block
// assumes a bind onto spfi_port and a single clock domain
`timescale 1ns/10ps
module spfi_port_chk
  import spfi_pkg::*;
(
  // clocking
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // sfr access
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrRdata,
  // pins and requests
  input wire spfi_pins_s pinIn,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic selGpio,
  input wire logic xferIrq,
  input wire logic modfIrq,
  input wire logic txeIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_rd_idle: assert property (ce && !sfrRd |=> sfrRdata == 8'h00)
    else $error("read data not zero without a read");
  chk_oe_pair: assert property (sckOe == mosiOe)
    else $error("clock and data enables differ");
  // misoOe is registered, so compare with the previous master enable
  chk_slave_only: assert property (misoOe |-> !$past(sckOe))
    else $error("slave output driven in master mode");
  chk_sel_tri: assert property (
    (ce && pinIn.selN && !selGpio)[*4] |-> !misoOe)
    else $error("slave output driven while deselected");
  chk_mst_fault: assert property (
    (ce && sckOe && !selGpio && !pinIn.selN)[*3] |-> ##[0:3] !sckOe)
    else $error("master kept enabled with select low");
  chk_irq_excl: assert property (!(xferIrq && txeIrq))
    else $error("transfer and empty requests together");
  chk_gpio_nomodf: assert property (
    selGpio && $past(selGpio) |-> !modfIrq)
    else $error("mode fault request with select disabled");
  chk_gpio_keep: assert property (
    selGpio && sckOe && !sfrWr |=> sckOe)
    else $error("master dropped with select disabled");
  chk_mode_fault_flag_hold: assert property (modfIrq && !sfrWr |=> modfIrq)
    else $error("mode fault cleared without control write");
  chk_xfer_hold: assert property (
    xferIrq && !sfrWr && !sfrRd |=> xferIrq)
    else $error("transfer request cleared without access");
endmodule
bind spfi_port spfi_port_chk spfi_port_chk_inst (.clk(clk),
  .resetn(resetn), .ce(ce), .sfrWr(sfrWr), .sfrRd(sfrRd),
  .sfrRdata(sfrRdata), .pinIn(pinIn), .sckOe(sckOe), .mosiOe(mosiOe),
  .misoOe(misoOe), .selGpio(selGpio), .xferIrq(xferIrq),
  .modfIrq(modfIrq), .txeIrq(txeIrq));

/* File: bench/spfi_peer.sv */
// behavioural slave peer facing the port in master mode
// assumes polarity 0, phase 0 and a peer that is always selected
`timescale 1ns/10ps
module spfi_peer (
  // lines from the master
  input wire logic sck,
  input wire logic mosi,
  input wire logic act,
  // byte to answer with
  input wire logic [7:0] txByte,
  // answer and capture
  output logic miso,
  output logic [7:0] rxByte
);
  int cnt = 0;
  initial rxByte = 8'h00;
  always @(posedge sck) rxByte <= {rxByte[6:0], mosi};
  // eight trailing edges end a byte, then the next starts at bit 7
  always @(negedge sck) cnt <= (cnt == 7) ? 0 : cnt + 1;
  // idle line shows the opposite level, not a stale bit
  assign miso = act ? txByte[3'd7 - cnt[2:0]] : ~txByte[3'd7 - cnt[2:0]];
endmodule

/* File: bench/spfi_port_tb.sv */
// self-checking testbench for the serial port control block
// assumes the peer model and the bound checker are compiled first
`timescale 1ns/10ps
`include "spfi_defs.svh"
module spfi_port_tb
  import spfi_pkg::*;
  ;
  localparam logic [7:0] AC = `SPFI_ADDR_CTRL;
  localparam logic [7:0] AS = `SPFI_ADDR_STAT;
  localparam logic [7:0] AD = `SPFI_ADDR_DATA;
  logic clk, resetn, ce, sfrWr, sfrRd, selN, peerMiso;
  logic [7:0] sfrAddr, sfrWdata, sfrRdata, peerRx, rdv;
  logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selGpio;
  logic xferIrq, modfIrq, txeIrq;
  spfi_pins_s pinIn;
  int fail_count = 0;
  int n_compared = 0;
  // wire levels resolved from each driver's enable
  assign pinIn = '{sckOe ? sckOut : 1'b0, mosiOe ? mosiOut : 1'b0,
                   misoOe ? misoOut : peerMiso, selN};
  spfi_port spfi_port_inst (.clk(clk), .resetn(resetn), .ce(ce),
    .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .pinIn(pinIn), .sckOut(sckOut), .sckOe(sckOe),
    .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOut(misoOut),
    .misoOe(misoOe), .selGpio(selGpio), .xferIrq(xferIrq),
    .modfIrq(modfIrq), .txeIrq(txeIrq));
  spfi_peer spfi_peer_inst (.sck(pinIn.sck), .mosi(pinIn.mosi),
    .act(sckOe), .txByte(8'h36), .miso(peerMiso), .rxByte(peerRx));
  task automatic wrap_up;
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one access, then a spare cycle so registered requests settle
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    #5;
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = w;
    sfrRd = !w;
    @(posedge clk);
    #5;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    rdv = sfrRdata;
    @(posedge clk);
    #5;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, rdv);
  endtask
  task automatic poll(input logic [7:0] m, input logic [7:0] e);
    int i;
    i = 0;
    do begin
      bus(1'b0, AS, 8'h00);
      i++;
    end while ((rdv & m) == 8'h00 && i < 200);
    chk("status", e, rdv);
  endtask
  task automatic idle;
    repeat (6) @(posedge clk);
    #5;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // far longer than the whole sequence needs
  initial begin
    #2000000;
    fail_count++;
    wrap_up();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    selN = 1'b1;
    repeat (10) @(posedge clk);
    #5;
    resetn = 1'b1;
    rd(AC, 8'h14, "ctrl");
    rd(AS, 8'h08, "status");
    // master at divide 16, second byte queued behind the first
    bus(1'b1, AC, 8'h53);
    bus(1'b1, AD, 8'ha5);
    bus(1'b1, AD, 8'h1e);
    poll(8'h80, 8'h88);
    chk("xferIrq", 8'h01, xferIrq);
    poll(8'h20, 8'ha8);
    chk("peerRx", 8'h1e, peerRx);
    bus(1'b1, AS, 8'h02);
    chk("txeIrq", 8'h01, txeIrq);
    chk("xferIrq", 8'h00, xferIrq);
    bus(1'b1, AS, 8'h00);
    chk("xferIrq", 8'h01, xferIrq);
    rd(AS, 8'h88, "status");
    rd(AD, 8'h36, "data");
    chk("xferIrq", 8'h00, xferIrq);
    rd(AS, 8'h08, "status");
    // master fault; enable refused until status read then control write
    bus(1'b1, AS, 8'h01);
    selN = 1'b0;
    idle();
    chk("modfIrq", 8'h01, modfIrq);
    rd(AC, 8'h03, "ctrl");
    selN = 1'b1;
    bus(1'b1, AC, 8'h53);
    rd(AC, 8'h13, "ctrl");
    rd(AS, 8'h19, "status");
    bus(1'b1, AC, 8'h53);
    rd(AC, 8'h53, "ctrl");
    chk("modfIrq", 8'h00, modfIrq);
    bus(1'b1, AC, 8'h73);
    selN = 1'b0;
    idle();
    chk("selGpio", 8'h01, selGpio);
    chk("modfIrq", 8'h00, modfIrq);
    rd(AC, 8'h73, "ctrl");
    selN = 1'b1;
    // slave selected then released with no clock
    bus(1'b1, AC, 8'h40);
    selN = 1'b0;
    idle();
    chk("misoOe", 8'h01, misoOe);
    selN = 1'b1;
    idle();
    chk("misoOe", 8'h00, misoOe);
    chk("modfIrq", 8'h01, modfIrq);
    rd(AS, 8'h19, "status");
    wrap_up();
  end
endmodule
